// ===== hw/flpc_pkg.sv
// Shared constants and types for the parallel flash pin control block.
package flpc_pkg;

  // ==========================================================================
  // Bus widths and array geometry
  // ==========================================================================
  localparam int DATA_W        = 16;
  localparam int ADDR_W        = 16;
  localparam int ARRAY_AW      = 4;
  localparam int NUM_BLOCKS    = 4;
  localparam int LATENCY_W     = 4;
  localparam int BUSY_W        = 8;

  // ==========================================================================
  // Command codes written on the data bus
  // ==========================================================================
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_READ_IDENT   = 8'h90;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM      = 8'h40;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
  localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
  localparam logic [7:0] CMD_LOCK_BLOCK   = 8'h01;
  localparam logic [7:0] CMD_LOCKDOWN     = 8'h2F;
  localparam logic [7:0] CMD_SET_CONFIG   = 8'h03;

  // ==========================================================================
  // Status register fields
  // ==========================================================================
  localparam int         SR_READY_BIT     = 7;
  localparam int         SR_ERASE_ERR_BIT = 5;
  localparam int         SR_PROG_ERR_BIT  = 4;
  localparam int         SR_SUPPLY_ERR_BIT = 3;
  localparam int         SR_LOCK_ERR_BIT  = 1;
  localparam logic [7:0] SR_RESET_VALUE   = 8'h80;
  localparam logic [7:0] SR_ERR_MASK      = 8'h3A;

  // ==========================================================================
  // Read configuration register fields
  // ==========================================================================
  localparam int                RCR_WAIT_POL_BIT = 10;
  localparam int                RCR_ASYNC_BIT    = 15;
  localparam logic [DATA_W-1:0] RCR_RESET_VALUE  = 16'h8000;

  // Identifier word; the value is arbitrary.
  localparam logic [DATA_W-1:0] IDENT_WORD       = 16'h0000;
  localparam logic [DATA_W-1:0] ERASED_WORD      = 16'hFFFF;

  // ==========================================================================
  // Software register port map
  // ==========================================================================
  localparam logic [7:0]           REG_STATUS      = 8'h00;
  localparam logic [7:0]           REG_CONFIG      = 8'h04;
  localparam logic [7:0]           REG_LOCKS       = 8'h08;
  localparam logic [7:0]           REG_LATENCY     = 8'h0C;
  localparam int                   LOCKDOWN_SHIFT  = 8;
  localparam logic [LATENCY_W-1:0] LATENCY_RESET   = 4'h3;

  // ==========================================================================
  // Automation timing in clock cycles
  // ==========================================================================
  localparam int PROG_CYCLES  = 16;
  localparam int ERASE_CYCLES = 64;

  // ==========================================================================
  // State types
  // ==========================================================================
  typedef enum logic [1:0] {
    FLPC_IDLE       = 2'b00,
    FLPC_PROG_DATA  = 2'b01,
    FLPC_ERASE_CONF = 2'b11,
    FLPC_LOCK_SUB   = 2'b10
  } flpc_cmd_state_type;

  typedef enum logic [1:0] {
    FLPC_RM_ARRAY  = 2'b00,
    FLPC_RM_STATUS = 2'b01,
    FLPC_RM_CONFIG = 2'b11,
    FLPC_RM_IDENT  = 2'b10
  } flpc_read_mode_type;

endpackage

// ===== hw/flpc_write_latch.sv
// Bus write cycle detector that latches address and data at the end of a cycle.
`timescale 1ns/1ns
module flpc_write_latch #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 16
) (
  input  wire logic              clock_i,
  input  wire logic              reset_i,
  input  wire logic              enable_i,
  input  wire logic              pin_reset_n_i,
  input  wire logic              chip_select_n_i,
  input  wire logic              output_drive_n_i,
  input  wire logic              write_strobe_n_i,
  input  wire logic [ADDR_W-1:0] address_i,
  input  wire logic [DATA_W-1:0] data_i,
  output logic                   write_pulse_o,
  output logic [ADDR_W-1:0]      write_addr_o,
  output logic [DATA_W-1:0]      write_data_o
);

  // ==========================================================================
  // Cycle tracking
  // ==========================================================================
  logic cycle_active_q;
  // A write cycle needs select and strobe low with reset and output drive high.
  wire cycle_now   = pin_reset_n_i & ~chip_select_n_i & ~write_strobe_n_i & output_drive_n_i;
  // The cycle ends on the first of the strobe or select rising edges.
  wire cycle_end   = cycle_active_q & ~cycle_now & pin_reset_n_i;

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cycle_active_q <= 1'b0;
      write_pulse_o  <= 1'b0;
      write_addr_o   <= '0;
      write_data_o   <= '0;
    end
    else if (enable_i)
    begin
      // Pin reset drops any open cycle so no write escapes it.
      cycle_active_q <= cycle_now;
      write_pulse_o  <= cycle_end;
      if (cycle_now)
      begin
        // Values from the last sampled low phase are the ones committed.
        write_addr_o <= address_i;
        write_data_o <= data_i;
      end
    end
  end

endmodule

// ===== hw/flpc_wait_gen.sv
// Wait output generator with configurable polarity and first-access latency.
`timescale 1ns/1ns
module flpc_wait_gen #(
  parameter int LATENCY_W = 4
) (
  input  wire logic                 clock_i,
  input  wire logic                 reset_i,
  input  wire logic                 enable_i,
  input  wire logic                 read_active_i,
  input  wire logic                 sync_mode_i,
  input  wire logic                 polarity_i,
  input  wire logic [LATENCY_W-1:0] latency_i,
  output logic                      wait_o,
  output logic                      wait_oe_o
);

  // ==========================================================================
  // Latency count from the start of a read
  // ==========================================================================
  logic [LATENCY_W-1:0] count_q;
  wire  [LATENCY_W-1:0] count_d    = !read_active_i ? '0 :
                                     (count_q == latency_i) ? count_q :
                                     count_q + 1'b1;
  // Only synchronous reads ever report invalid data.
  wire                  not_valid  = sync_mode_i & read_active_i & (count_q != latency_i);
  // The asserted level follows the polarity bit.
  wire                  wait_level = not_valid ? polarity_i : ~polarity_i;

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      count_q   <= '0;
      wait_o    <= 1'b0;
      wait_oe_o <= 1'b0;
    end
    else if (enable_i)
    begin
      count_q   <= count_d;
      wait_o    <= wait_level;
      // Drive only while select and output drive are both low.
      wait_oe_o <= read_active_i;
    end
  end

endmodule

// ===== hw/flpc_pin_control.sv
// Pin-level control of a parallel NOR flash: reset, protection, writes, data bus and wait.
// Functional notes
// - Pin reset low resets automation and ignores all bus writes.
// - Leaving pin reset returns to asynchronous array read mode.
// - Write protect low: locked-down blocks stay locked despite unlock commands.
// - Write protect high: lock-down is ignored, blocks may be unlocked and altered.
// - Address and data latch on first rising edge of strobe or select.
// - Program and erase are refused while the program supply is not valid.
// - Data bus takes words on writes, drives array, status or ident on reads.
// - Data bus floats whenever select or output drive is high.
// - Wait polarity follows bit 10 of the read configuration register.
// - Synchronous reads assert wait until data is valid.
// - Asynchronous reads and all writes keep wait deasserted.
// - Wait floats when select or output drive is high, driven only when both low.
// - Array writes are blocked while the core supply is not valid.
// - Status register comes up as 0x80 after power-up or pin reset.
// - Pin reset during program or erase aborts it at once.
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ns
module flpc_pin_control #(
  parameter int ADDR_W       = flpc_pkg::ADDR_W,
  parameter int ARRAY_AW     = flpc_pkg::ARRAY_AW,
  parameter int NUM_BLOCKS   = flpc_pkg::NUM_BLOCKS,
  parameter int PROG_CYCLES  = flpc_pkg::PROG_CYCLES,
  parameter int ERASE_CYCLES = flpc_pkg::ERASE_CYCLES
) (
  input  wire logic                        clock_i,
  input  wire logic                        reset_i,
  input  wire logic                        enable_i,
  input  wire logic                        reset_in_n_i,
  input  wire logic                        chip_select_n_i,
  input  wire logic                        output_drive_n_i,
  input  wire logic                        write_strobe_n_i,
  input  wire logic                        write_protect_n_i,
  input  wire logic                        program_supply_ok_i,
  input  wire logic                        core_supply_ok_i,
  input  wire logic [ADDR_W-1:0]           address_i,
  input  wire logic [flpc_pkg::DATA_W-1:0] data_bus_i,
  output logic      [flpc_pkg::DATA_W-1:0] data_bus_o,
  output logic                             data_bus_oe_o,
  output logic                             wait_o,
  output logic                             wait_oe_o,
  input  wire logic [7:0]                  reg_addr_i,
  input  wire logic [31:0]                 reg_wdata_i,
  input  wire logic                        reg_write_i,
  input  wire logic                        reg_read_i,
  output logic      [31:0]                 reg_rdata_o
);

  localparam int DW    = flpc_pkg::DATA_W;
  localparam int DEPTH = 1 << ARRAY_AW;
  localparam int BLK_W = $clog2(NUM_BLOCKS);
  localparam int LW    = flpc_pkg::LATENCY_W;
  localparam int BW    = flpc_pkg::BUSY_W;
  localparam logic [BW-1:0] PROG_LAST  = BW'(PROG_CYCLES - 1);
  localparam logic [BW-1:0] ERASE_LAST = BW'(ERASE_CYCLES - 1);

  // ==========================================================================
  // Write cycle capture
  // ==========================================================================
  logic              wr_pulse;
  logic [ADDR_W-1:0] wr_addr;
  logic [DW-1:0]     wr_data;

  flpc_write_latch #(
    .ADDR_W (ADDR_W),
    .DATA_W (DW)
  ) u_write_latch (
    .clock_i          (clock_i),
    .reset_i          (reset_i),
    .enable_i         (enable_i),
    .pin_reset_n_i    (reset_in_n_i),
    .chip_select_n_i  (chip_select_n_i),
    .output_drive_n_i (output_drive_n_i),
    .write_strobe_n_i (write_strobe_n_i),
    .address_i        (address_i),
    .data_i           (data_bus_i),
    .write_pulse_o    (wr_pulse),
    .write_addr_o     (wr_addr),
    .write_data_o     (wr_data)
  );

  // ==========================================================================
  // State
  // ==========================================================================
  flpc_pkg::flpc_cmd_state_type state_q,  state_d;
  flpc_pkg::flpc_read_mode_type rmode_q,  rmode_d;
  logic [7:0]                   status_q, status_d;
  logic [DW-1:0]                rcr_q,    rcr_d;
  logic [NUM_BLOCKS-1:0]        lock_q,   lock_d;
  logic [NUM_BLOCKS-1:0]        down_q,   down_d;
  logic                         busy_q,   busy_d;
  logic                         op_erase_q, op_erase_d;
  logic [ARRAY_AW-1:0]          op_addr_q,  op_addr_d;
  logic [DW-1:0]                op_data_q,  op_data_d;
  logic [BW-1:0]                busy_cnt_q, busy_cnt_d;
  logic [LW-1:0]                latency_q;
  logic [DW-1:0]                array_q [DEPTH];

  // ==========================================================================
  // Decode
  // ==========================================================================
  wire [7:0]          cmd        = wr_data[7:0];
  wire [ARRAY_AW-1:0] wr_index   = wr_addr[ARRAY_AW-1:0];
  wire [BLK_W-1:0]    wr_block   = wr_index[ARRAY_AW-1 -: BLK_W];
  wire [BLK_W-1:0]    op_block   = op_addr_q[ARRAY_AW-1 -: BLK_W];
  wire                blk_locked = lock_q[wr_block];
  // Lock-down only holds a block while write protect is low.
  wire                unlock_ok  = ~down_q[wr_block] | write_protect_n_i;
  wire                accept_wr  = wr_pulse & reset_in_n_i & ~busy_q;
  wire [BW-1:0]       op_last    = op_erase_q ? ERASE_LAST : PROG_LAST;
  wire                op_done    = busy_q & (busy_cnt_q == op_last);
  wire                read_active = reset_in_n_i & ~chip_select_n_i & ~output_drive_n_i;
  wire                sync_mode  = ~rcr_q[flpc_pkg::RCR_ASYNC_BIT];
  wire [ARRAY_AW-1:0] rd_index   = address_i[ARRAY_AW-1:0];

  // ==========================================================================
  // Command sequencer
  // ==========================================================================
  always_comb
  begin
    state_d    = state_q;
    rmode_d    = rmode_q;
    status_d   = status_q;
    rcr_d      = rcr_q;
    lock_d     = lock_q;
    down_d     = down_q;
    busy_d     = busy_q;
    op_erase_d = op_erase_q;
    op_addr_d  = op_addr_q;
    op_data_d  = op_data_q;
    busy_cnt_d = busy_q ? busy_cnt_q + 1'b1 : '0;
    if (op_done)
    begin
      busy_d = 1'b0;
    end
    if (accept_wr)
    begin
      state_d = flpc_pkg::FLPC_IDLE;
      case (state_q)
        flpc_pkg::FLPC_IDLE:
        begin
          case (cmd)
            flpc_pkg::CMD_READ_ARRAY:   rmode_d  = flpc_pkg::FLPC_RM_ARRAY;
            flpc_pkg::CMD_READ_STATUS:  rmode_d  = flpc_pkg::FLPC_RM_STATUS;
            flpc_pkg::CMD_READ_IDENT:   rmode_d  = flpc_pkg::FLPC_RM_IDENT;
            flpc_pkg::CMD_CLEAR_STATUS: status_d = status_q & ~flpc_pkg::SR_ERR_MASK;
            flpc_pkg::CMD_PROGRAM:      state_d  = flpc_pkg::FLPC_PROG_DATA;
            flpc_pkg::CMD_ERASE_SETUP:  state_d  = flpc_pkg::FLPC_ERASE_CONF;
            flpc_pkg::CMD_LOCK_SETUP:   state_d  = flpc_pkg::FLPC_LOCK_SUB;
            default:                    state_d  = flpc_pkg::FLPC_IDLE;
          endcase
        end
        flpc_pkg::FLPC_PROG_DATA, flpc_pkg::FLPC_ERASE_CONF:
        begin
          rmode_d = flpc_pkg::FLPC_RM_STATUS;
          if (state_q == flpc_pkg::FLPC_ERASE_CONF && cmd != flpc_pkg::CMD_CONFIRM)
          begin
            status_d[flpc_pkg::SR_ERASE_ERR_BIT] = 1'b1;
            status_d[flpc_pkg::SR_PROG_ERR_BIT]  = 1'b1;
          end
          else if (!program_supply_ok_i)
          begin
            // Low program supply refuses any change to the array.
            status_d[flpc_pkg::SR_SUPPLY_ERR_BIT] = 1'b1;
            status_d[flpc_pkg::SR_PROG_ERR_BIT]   = 1'b1;
          end
          else if (!core_supply_ok_i)
          begin
            // Low core supply blocks array writes.
            status_d[flpc_pkg::SR_PROG_ERR_BIT] = 1'b1;
          end
          else if (blk_locked)
          begin
            status_d[flpc_pkg::SR_LOCK_ERR_BIT] = 1'b1;
            status_d[flpc_pkg::SR_PROG_ERR_BIT] = 1'b1;
          end
          else
          begin
            busy_d     = 1'b1;
            op_erase_d = (state_q == flpc_pkg::FLPC_ERASE_CONF);
            op_addr_d  = wr_index;
            op_data_d  = wr_data;
          end
        end
        flpc_pkg::FLPC_LOCK_SUB:
        begin
          case (cmd)
            flpc_pkg::CMD_LOCK_BLOCK: lock_d[wr_block] = 1'b1;
            // An unlock of a locked-down block is dropped while protect is low.
            flpc_pkg::CMD_CONFIRM:    lock_d[wr_block] = ~unlock_ok;
            flpc_pkg::CMD_LOCKDOWN:
            begin
              lock_d[wr_block] = 1'b1;
              down_d[wr_block] = 1'b1;
            end
            flpc_pkg::CMD_SET_CONFIG: rcr_d = wr_addr[DW-1:0];
            default:                  rcr_d = rcr_q;
          endcase
        end
        default: state_d = flpc_pkg::FLPC_IDLE;
      endcase
    end
    status_d[flpc_pkg::SR_READY_BIT] = ~busy_d;
  end

  // ==========================================================================
  // State registers
  // ==========================================================================
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_q    <= flpc_pkg::FLPC_IDLE;
      rmode_q    <= flpc_pkg::FLPC_RM_ARRAY;
      status_q   <= flpc_pkg::SR_RESET_VALUE;
      rcr_q      <= flpc_pkg::RCR_RESET_VALUE;
      lock_q     <= '1;
      down_q     <= '0;
      busy_q     <= 1'b0;
      op_erase_q <= 1'b0;
      op_addr_q  <= '0;
      op_data_q  <= '0;
      busy_cnt_q <= '0;
    end
    else if (enable_i)
    begin
      if (!reset_in_n_i)
      begin
        // Pin reset aborts automation and restores read array mode.
        state_q    <= flpc_pkg::FLPC_IDLE;
        rmode_q    <= flpc_pkg::FLPC_RM_ARRAY;
        status_q   <= flpc_pkg::SR_RESET_VALUE;
        rcr_q      <= flpc_pkg::RCR_RESET_VALUE;
        lock_q     <= '1;
        down_q     <= '0;
        busy_q     <= 1'b0;
        busy_cnt_q <= '0;
      end
      else
      begin
        state_q    <= state_d;
        rmode_q    <= rmode_d;
        status_q   <= status_d;
        rcr_q      <= rcr_d;
        lock_q     <= lock_d;
        down_q     <= down_d;
        busy_q     <= busy_d;
        op_erase_q <= op_erase_d;
        op_addr_q  <= op_addr_d;
        op_data_q  <= op_data_d;
        busy_cnt_q <= busy_cnt_d;
      end
    end
  end

  // ==========================================================================
  // Array storage
  // ==========================================================================
  // The array only changes on completion, so an aborted operation leaves the
  // target word or block as it was; hosts must still treat it as undefined.
  wire commit = op_done & reset_in_n_i;

  for (genvar w = 0; w < DEPTH; w++)
  begin : g_word
    localparam logic [ARRAY_AW-1:0] IDX = ARRAY_AW'(w);
    wire hit_word  = ~op_erase_q & (op_addr_q == IDX);
    wire hit_block = op_erase_q & (op_block == IDX[ARRAY_AW-1 -: BLK_W]);
    always_ff @(posedge clock_i or posedge reset_i)
    begin
      if (reset_i)
      begin
        array_q[w] <= flpc_pkg::ERASED_WORD;
      end
      else if (enable_i && commit && hit_block)
      begin
        array_q[w] <= flpc_pkg::ERASED_WORD;
      end
      else if (enable_i && commit && hit_word)
      begin
        array_q[w] <= array_q[w] & op_data_q;
      end
    end
  end

  // ==========================================================================
  // Data bus read path
  // ==========================================================================
  // Read source chosen by the current read mode.
  wire [DW-1:0] rd_word = (rmode_q == flpc_pkg::FLPC_RM_STATUS) ? {8'h00, status_q} :
                          (rmode_q == flpc_pkg::FLPC_RM_CONFIG) ? rcr_q :
                          (rmode_q == flpc_pkg::FLPC_RM_IDENT)  ? flpc_pkg::IDENT_WORD :
                          array_q[rd_index];

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      data_bus_o    <= '0;
      data_bus_oe_o <= 1'b0;
    end
    else if (enable_i)
    begin
      data_bus_o    <= read_active ? rd_word : '0;
      data_bus_oe_o <= read_active;
    end
  end

  // ==========================================================================
  // Wait output
  // ==========================================================================
  flpc_wait_gen #(
    .LATENCY_W (LW)
  ) u_wait_gen (
    .clock_i       (clock_i),
    .reset_i       (reset_i),
    .enable_i      (enable_i),
    .read_active_i (read_active),
    .sync_mode_i   (sync_mode),
    .polarity_i    (rcr_q[flpc_pkg::RCR_WAIT_POL_BIT]),
    .latency_i     (latency_q),
    .wait_o        (wait_o),
    .wait_oe_o     (wait_oe_o)
  );

  // ==========================================================================
  // Software register port
  // ==========================================================================
  localparam int LOCKDOWN_TOP = flpc_pkg::LOCKDOWN_SHIFT + NUM_BLOCKS;
  wire [31:0] locks_word = {{(32 - LOCKDOWN_TOP){1'b0}},
                            down_q, {(flpc_pkg::LOCKDOWN_SHIFT - NUM_BLOCKS){1'b0}}, lock_q};
  wire [31:0] reg_word   = (reg_addr_i == flpc_pkg::REG_STATUS)  ? {24'h000000, status_q} :
                           (reg_addr_i == flpc_pkg::REG_CONFIG)  ? {16'h0000, rcr_q} :
                           (reg_addr_i == flpc_pkg::REG_LOCKS)   ? locks_word :
                           (reg_addr_i == flpc_pkg::REG_LATENCY) ? {28'h0000000, latency_q} :
                           32'h00000000;

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      reg_rdata_o <= '0;
      latency_q   <= flpc_pkg::LATENCY_RESET;
    end
    else if (enable_i)
    begin
      reg_rdata_o <= reg_read_i ? reg_word : '0;
      if (reg_write_i && reg_addr_i == flpc_pkg::REG_LATENCY)
      begin
        latency_q <= reg_wdata_i[LW-1:0];
      end
    end
  end

endmodule

// ===== dv/flpc_pin_monitor.sv
// Port checker for the flash pin control block.
`timescale 1ns/1ns
module flpc_pin_monitor (
  input wire logic        clock_i,
  input wire logic        reset_i,
  input wire logic        enable_i,
  input wire logic        reset_in_n_i,
  input wire logic        chip_select_n_i,
  input wire logic        output_drive_n_i,
  input wire logic        write_strobe_n_i,
  input wire logic        data_bus_oe_o,
  input wire logic        wait_oe_o,
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_read_i,
  input wire logic [31:0] reg_rdata_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  chk_bus_float:
    assert property (enable_i && (chip_select_n_i || output_drive_n_i) |=> !data_bus_oe_o)
    else $error("data bus driven while deselected");
  chk_wait_float:
    assert property (wait_oe_o == data_bus_oe_o) else $error("wait drive mismatch");
  chk_read_drive:
    assert property (enable_i && reset_in_n_i && !chip_select_n_i && !output_drive_n_i
      |=> data_bus_oe_o) else $error("read not driven");
  chk_pin_reset:
    assert property (enable_i && !reset_in_n_i |=> !data_bus_oe_o && !wait_oe_o)
    else $error("outputs driven in pin reset");
  chk_write_wait:
    assert property (enable_i && !write_strobe_n_i && output_drive_n_i |=> !wait_oe_o)
    else $error("wait driven in write");
  chk_status_init:
    assert property (enable_i && !reset_in_n_i ##1 (reg_read_i && reg_addr_i == 8'h00)
      |=> reg_rdata_o == 32'h80) else $error("status not 80 after pin reset");
  chk_config_init:
    assert property (enable_i && !reset_in_n_i ##1 (reg_read_i && reg_addr_i == 8'h04)
      |=> reg_rdata_o == 32'h8000) else $error("config not async after pin reset");
  chk_drive_cause:
    assert property (data_bus_oe_o && $past(enable_i)
      |-> $past(!chip_select_n_i && !output_drive_n_i)) else $error("drive without select");
endmodule
bind flpc_pin_control flpc_pin_monitor mon (.clock_i(clock_i), .reset_i(reset_i),
  .enable_i(enable_i), .reset_in_n_i(reset_in_n_i), .chip_select_n_i(chip_select_n_i),
  .output_drive_n_i(output_drive_n_i), .write_strobe_n_i(write_strobe_n_i),
  .data_bus_oe_o(data_bus_oe_o), .wait_oe_o(wait_oe_o), .reg_addr_i(reg_addr_i),
  .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o));

// ===== dv/flpc_host_model.sv
// Host bus master model for the flash pin bus.
`timescale 1ns/1ns
module flpc_host_model (
  input  wire logic   clock_i,
  output logic        cs_n_o,
  output logic        oe_n_o,
  output logic        we_n_o,
  output logic [15:0] addr_o,
  output logic [15:0] data_o
);
  initial {cs_n_o, oe_n_o, we_n_o, addr_o, data_o} = {3'h7, 32'h0};
  // Lines are scrambled once the strobe rises, so late capture would show.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock_i);
    {cs_n_o, we_n_o, addr_o, data_o} <= {2'h0, a, d};
    @(posedge clock_i);
    {we_n_o, addr_o, data_o} <= {1'b1, ~a, ~d};
    @(posedge clock_i);
    cs_n_o <= 1'b1;
    repeat (3) @(posedge clock_i);
  endtask
  task automatic rd(input logic [15:0] a, input logic on);
    @(posedge clock_i);
    {cs_n_o, oe_n_o, addr_o} <= {~on, ~on, a};
  endtask
endmodule

// ===== dv/testbench.sv
// Self-checking bench for the flash pin control block.
`timescale 1ns/1ns
module testbench;
  logic        clock_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        rst_n = 1'b1, wp_n = 1'b1, vpp_ok = 1'b1, vcc_ok = 1'b1, rwr = 1'b0, rrd = 1'b0;
  logic        cs_n, oe_n, we_n, dq_oe, wt, wt_oe;
  logic [15:0] addr, dq, dout;
  logic [7:0]  ra = 8'h00;
  logic [31:0] rw = 32'h0, rdat, v;
  int          err_count = 0, check_count = 0, x = 76839, a, d, lat, n;
  always #5 clock_i = ~clock_i;
  flpc_host_model host (.clock_i(clock_i), .cs_n_o(cs_n), .oe_n_o(oe_n), .we_n_o(we_n),
    .addr_o(addr), .data_o(dq));
  flpc_pin_control #(.PROG_CYCLES(8)) dut (.clock_i(clock_i), .reset_i(reset_i),
    .enable_i(1'b1), .reset_in_n_i(rst_n), .chip_select_n_i(cs_n), .output_drive_n_i(oe_n),
    .write_strobe_n_i(we_n), .write_protect_n_i(wp_n), .program_supply_ok_i(vpp_ok),
    .core_supply_ok_i(vcc_ok), .address_i(addr), .data_bus_i(dq), .data_bus_o(dout),
    .data_bus_oe_o(dq_oe), .wait_o(wt), .wait_oe_o(wt_oe), .reg_addr_i(ra),
    .reg_wdata_i(rw), .reg_write_i(rwr), .reg_read_i(rrd), .reg_rdata_o(rdat));
  function automatic int xs();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic rreg(input logic [7:0] ad, input logic w, input logic [31:0] wd);
    @(posedge clock_i);
    {ra, rw, rwr, rrd} <= {ad, wd, w, ~w};
    @(posedge clock_i);
    {rwr, rrd} <= 2'b00;
    #1 v = rdat;
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
    rreg(ad, 1'b0, 32'h0);
    chk(v, exp);
  endtask
  task automatic seq2(input logic [15:0] ad, input logic [15:0] c1, input logic [15:0] c2);
    host.wr(ad, c1);
    host.wr(ad, c2);
  endtask
  task automatic arr(input logic [15:0] ad, input logic [15:0] exp);
    host.rd(ad, 1'b1);
    repeat (2) @(posedge clock_i);
    #1 chk(dout, exp);
    chk({wt_oe, wt}, 2'b11);
    host.rd(ad, 1'b0);
  endtask
  initial
  begin
    repeat (20) @(posedge clock_i);
    reset_i <= 1'b0;
    rchk(8'h00, 32'h80);
    rchk(8'h04, 32'h8000);
    rchk(8'h10, 32'h0);
    arr(5, 16'hFFFF);
    lat = 1 + (xs() & 3);
    rreg(8'h0C, 1'b1, lat);
    rchk(8'h0C, lat);
    a = 4 + (xs() & 3);
    d = xs() & 16'hFFFF;
    seq2(a, 16'h60, 16'hD0);
    seq2(a, 16'h40, d);
    for (n = 0; n < 40 && v[7] !== 1'b1; n++)
      rreg(8'h00, 1'b0, 32'h0);
    if (n == 40)
      err_count++;
    host.wr(a, 16'hFF);
    arr(a, d);
    vpp_ok <= 1'b0;
    seq2(a, 16'h40, 16'h0);
    rchk(8'h00, 32'h98);
    host.wr(a, 16'h50);
    {vpp_ok, vcc_ok} <= 2'b10;
    seq2(a, 16'h40, 16'h0);
    rchk(8'h00, 32'h90);
    host.wr(a, 16'h50);
    vcc_ok <= 1'b1;
    seq2(a, 16'h40, 16'h0);
    rst_n <= 1'b0;
    rchk(8'h00, 32'h80);
    rchk(8'h04, 32'h8000);
    rst_n <= 1'b1;
    arr(a, d);
    seq2(a, 16'h60, 16'h2F);
    wp_n <= 1'b0;
    seq2(a, 16'h60, 16'hD0);
    rchk(8'h08, 32'h20F);
    wp_n <= 1'b1;
    seq2(a, 16'h60, 16'hD0);
    rchk(8'h08, 32'h20D);
    seq2(16'h0400, 16'h60, 16'h03);
    rchk(8'h04, 32'h0400);
    host.rd(0, 1'b1);
    n = 0;
    repeat (10)
    begin
      @(posedge clock_i);
      #1 n += (wt_oe === 1'b1 && wt === 1'b1);
    end
    chk(n, lat);
    chk(wt, 1'b0);
    host.rd(0, 1'b0);
    tally_and_finish();
  end
endmodule
